// file: src/four_level_interrupt_priority.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module four_level_interrupt_priority
    import irq_prio_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Sources
    input  wire logic        ext0_pin_n,
    input  wire logic        ext1_pin_n,
    input  wire logic [7:0]  periph_request,
    output logic [7:0]       request_flag_clear,
    // Core sequencer
    output logic             irq_request,
    output logic [7:0]       irq_vector,
    output logic [1:0]       irq_level,
    input  wire logic        irq_ack,
    input  wire logic        irq_return,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] enable_reg_primary;
    logic [7:0] enable_reg_secondary;
    logic [7:0] priority_reg_upper;
    logic [7:0] priority_reg_lower;
    logic [7:0] trigger_mode;
    logic [7:0] event_status;
    logic [7:0] event_mask;

    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic [7:0]  wr_idx;
    logic [7:0]  next_event_status;
    logic [7:0]  event_set;

    function automatic logic [7:0] reg_index(input logic [11:0] addr);
        return addr[9:2];
    endfunction : reg_index

    function automatic logic addr_mapped(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        return (addr[11:10] == 2'b00) &&
               (idx == IDX_ENABLE_PRIMARY || idx == IDX_PRIORITY_UPPER || idx == IDX_PRIORITY_LOWER ||
                idx == IDX_ENABLE_SECONDARY || idx == IDX_TRIGGER_MODE || idx == IDX_EVENT_STATUS ||
                idx == IDX_EVENT_MASK || idx == IDX_CORE_STATE);
    endfunction : addr_mapped

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx        = reg_index(aw_addr);

    // Address and data may come in either order; the response follows both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Only byte lane 0 carries register data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_reg_primary   <= RST_REG;
            enable_reg_secondary <= RST_REG;
            priority_reg_upper   <= RST_REG;
            priority_reg_lower   <= RST_REG;
            trigger_mode         <= RST_REG;
            event_mask           <= RST_REG;
        end
        else if (do_write && w_strb[0] && addr_mapped(aw_addr))
        begin
            case (wr_idx)
                IDX_ENABLE_PRIMARY:   enable_reg_primary   <= w_data[7:0];
                IDX_PRIORITY_UPPER:   priority_reg_upper   <= w_data[7:0];
                IDX_PRIORITY_LOWER:   priority_reg_lower   <= w_data[7:0];
                IDX_ENABLE_SECONDARY: enable_reg_secondary <= w_data[7:0];
                IDX_TRIGGER_MODE:     trigger_mode         <= w_data[7:0];
                IDX_EVENT_MASK:       event_mask           <= w_data[7:0];
                default:              ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External pins and request flags

    logic [2:0] ext0_sync;
    logic [2:0] ext1_sync;
    logic       ext0_low;
    logic       ext1_low;
    logic       ext0_low_d;
    logic       ext1_low_d;
    logic       ext0_request_flag;
    logic       ext1_request_flag;
    logic [7:0] source_flags;
    logic [7:0] source_enable;
    logic [7:0] granted_onehot;
    logic       take;

    // Pin level accepted only once the last two stages agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext0_sync  <= 3'b111;
            ext1_sync  <= 3'b111;
            ext0_low   <= 1'b0;
            ext1_low   <= 1'b0;
            ext0_low_d <= 1'b0;
            ext1_low_d <= 1'b0;
        end
        else
        begin
            ext0_sync  <= {ext0_sync[1:0], ext0_pin_n};
            ext1_sync  <= {ext1_sync[1:0], ext1_pin_n};
            if (ext0_sync[1] == ext0_sync[2])
                ext0_low <= !ext0_sync[2];
            if (ext1_sync[1] == ext1_sync[2])
                ext1_low <= !ext1_sync[2];
            ext0_low_d <= ext0_low;
            ext1_low_d <= ext1_low;
        end
    end

    // Edge mode latches a falling edge; level mode follows the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext0_request_flag <= 1'b0;
            ext1_request_flag <= 1'b0;
        end
        else
        begin
            if (!trigger_mode[MODE_EXT0_EDGE])
                ext0_request_flag <= ext0_low;
            else if (ext0_low && !ext0_low_d)
                ext0_request_flag <= 1'b1;                                     // A new edge beats the clear
            else if (take && granted_onehot[SRC_EXT0])
                ext0_request_flag <= 1'b0;
            if (!trigger_mode[MODE_EXT1_EDGE])
                ext1_request_flag <= ext1_low;
            else if (ext1_low && !ext1_low_d)
                ext1_request_flag <= 1'b1;
            else if (take && granted_onehot[SRC_EXT1])
                ext1_request_flag <= 1'b0;
        end
    end

    always_comb
    begin
        source_flags = periph_request;
        source_flags[SRC_EXT0] = ext0_request_flag;
        source_flags[SRC_EXT1] = ext1_request_flag;
        source_enable = {enable_reg_secondary[EN2_TIMER2], enable_reg_primary[6:0]};
        if (!enable_reg_primary[EN_GLOBAL])
            source_enable = '0;
    end

    // Timer0 and timer1 clear their own overflow flag when vectored; timer2 does not
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            request_flag_clear <= '0;
        else
            request_flag_clear <= take ? (granted_onehot & 8'h0a) : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration and nesting

    logic [3:0] in_service;
    logic       busy;
    logic [1:0] top_level;
    logic       cand_found;
    logic [7:0] cand_vector;
    logic [1:0] cand_level;
    logic [7:0] cand_onehot;
    logic       settle;

    level_nest_tracker #(
        .LEVELS     (NUM_LEVELS)
    ) u_nest (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .push       (take),
        .push_level (irq_level),
        .pop        (irq_return),
        .in_service (in_service),
        .busy       (busy),
        .top_level  (top_level)
    );

    // Highest level wins; ties go to the earlier poll slot
    always_comb
    begin
        int   src;
        logic [1:0] lvl;
        src         = 0;
        lvl         = 2'd0;
        cand_found  = 1'b0;
        cand_vector = 8'h00;
        cand_level  = 2'd0;
        cand_onehot = 8'h00;
        for (int k = 0; k < NUM_SOURCES; k++)
        begin
            src = POLL_ORDER[k];
            lvl = {priority_reg_upper[src], priority_reg_lower[src]};
            if (source_flags[src] && source_enable[src] && (!busy || lvl > top_level) &&
                (!cand_found || lvl > cand_level))
            begin
                cand_found  = 1'b1;
                cand_level  = lvl;
                cand_vector = POLL_VECTOR[k];
                cand_onehot = 8'h01 << src;
            end
        end
    end

    // Registered candidate; a one-cycle settle hides stale state after a grant or return
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_vector     <= 8'h00;
            irq_level      <= 2'd0;
            granted_onehot <= 8'h00;
            settle         <= 1'b1;
        end
        else
        begin
            irq_vector     <= cand_vector;
            irq_level      <= cand_level;
            granted_onehot <= cand_onehot;
            settle         <= take || irq_return;
        end
    end

    logic cand_valid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cand_valid <= 1'b0;
        else
            cand_valid <= cand_found;
    end

    assign irq_request = cand_valid && !settle && !irq_return;
    assign take        = irq_request && irq_ack;

    ////////////////////////////////////////////////////////////////////////////
    // Event status and interrupt output

    always_comb
    begin
        event_set = 8'h00;
        event_set[EV_VECTORED]  = take;
        event_set[EV_PREEMPTED] = take && busy;
        event_set[EV_RETURNED]  = irq_return && busy;
        event_set[EV_BAD_RET]   = irq_return && !busy;
        next_event_status = event_status;
        if (do_write && w_strb[0] && wr_idx == IDX_EVENT_STATUS && addr_mapped(aw_addr))
            next_event_status = event_status & ~w_data[7:0];
        next_event_status = next_event_status | event_set;                     // Set wins over clear
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            event_status <= RST_REG;
        else
            event_status <= next_event_status;
    end

    assign irq = |(event_status & event_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    logic [7:0] rd_byte;

    always_comb
    begin
        case (reg_index(s_axi_araddr))
            IDX_ENABLE_PRIMARY:   rd_byte = enable_reg_primary;
            IDX_PRIORITY_UPPER:   rd_byte = priority_reg_upper;
            IDX_PRIORITY_LOWER:   rd_byte = priority_reg_lower;
            IDX_ENABLE_SECONDARY: rd_byte = enable_reg_secondary;
            IDX_TRIGGER_MODE:     rd_byte = trigger_mode;
            IDX_EVENT_STATUS:     rd_byte = event_status;
            IDX_EVENT_MASK:       rd_byte = event_mask;
            IDX_CORE_STATE:       rd_byte = {2'b00, ext1_request_flag, ext0_request_flag, in_service};
            default:              rd_byte = 8'h00;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= addr_mapped(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h00000000;
            s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule : four_level_interrupt_priority

// file: inc/irq_prio_pkg.sv
package irq_prio_pkg;

    localparam int NUM_SOURCES = 8;
    localparam int NUM_LEVELS  = 4;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_ENABLE_PRIMARY   = 8'ha8;
    localparam logic [7:0] IDX_PRIORITY_UPPER   = 8'hb7;
    localparam logic [7:0] IDX_PRIORITY_LOWER   = 8'hb8;
    localparam logic [7:0] IDX_ENABLE_SECONDARY = 8'he8;
    localparam logic [7:0] IDX_TRIGGER_MODE     = 8'he9;
    localparam logic [7:0] IDX_EVENT_STATUS     = 8'hf0;
    localparam logic [7:0] IDX_EVENT_MASK       = 8'hf1;
    localparam logic [7:0] IDX_CORE_STATE       = 8'hf2;

    localparam logic [7:0] RST_REG = 8'h00;

    // Bit positions shared by priority registers and request vector
    localparam int SRC_EXT0    = 0;
    localparam int SRC_TIMER0  = 1;
    localparam int SRC_EXT1    = 2;
    localparam int SRC_TIMER1  = 3;
    localparam int SRC_SERIAL  = 4;
    localparam int SRC_TWOWIRE = 5;
    localparam int SRC_COUNTER = 6;
    localparam int SRC_TIMER2  = 7;

    // Enable and trigger mode register fields
    localparam int EN_GLOBAL      = 7;
    localparam int EN2_TIMER2     = 0;
    localparam int MODE_EXT0_EDGE = 0;
    localparam int MODE_EXT1_EDGE = 1;

    // Event status fields
    localparam int EV_VECTORED  = 0;
    localparam int EV_PREEMPTED = 1;
    localparam int EV_RETURNED  = 2;
    localparam int EV_BAD_RET   = 3;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Arbitration order within one level and the matching vectors
    localparam int POLL_ORDER [NUM_SOURCES] = '{SRC_EXT0, SRC_TWOWIRE, SRC_TIMER0, SRC_EXT1,
                                                SRC_TIMER1, SRC_SERIAL, SRC_TIMER2, SRC_COUNTER};
    localparam logic [7:0] POLL_VECTOR [NUM_SOURCES] = '{8'h03, 8'h2b, 8'h0b, 8'h13,
                                                         8'h1b, 8'h23, 8'h3b, 8'h33};

endpackage : irq_prio_pkg

// file: src/level_nest_tracker.sv
`timescale 1ns/1ns
module level_nest_tracker
    import irq_prio_pkg::*;
#(
    parameter int LEVELS = NUM_LEVELS
)
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    push,
    input  wire logic [1:0]              push_level,
    input  wire logic                    pop,
    output logic      [LEVELS-1:0]       in_service,
    output logic                         busy,
    output logic      [1:0]              top_level
);

    initial
    begin
        if (LEVELS != 4)
            $error("level_nest_tracker serves exactly four levels");
    end

    // One bit per level suffices: only a strictly higher level may nest
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            in_service <= '0;
        else if (push)
            in_service <= in_service | (LEVELS'(1) << push_level);
        else if (pop && busy)
            in_service <= in_service & ~(LEVELS'(1) << top_level);
    end

    always_comb
    begin
        top_level = 2'd0;
        for (int i = 0; i < LEVELS; i++)
            if (in_service[i])
                top_level = 2'(i);
    end

    assign busy = |in_service;

endmodule : level_nest_tracker

// file: dv/four_level_interrupt_priority_sva.sv
`timescale 1ns/1ns
module irq_prio_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  request_flag_clear,
    input wire logic        irq_request,
    input wire logic [7:0]  irq_vector,
    input wire logic [1:0]  irq_level,
    input wire logic        irq_ack,
    input wire logic        irq_return
);
    logic [3:0] svc;
    logic [1:0] top;
    // Shadow of the levels in service
    always_comb
        top = svc[3] ? 2'h3 : svc[2] ? 2'h2 : svc[1] ? 2'h1 : 2'h0;
    always_ff @(posedge aclk)
        if (!aresetn)
            svc <= 4'h0;
        else if (irq_request && irq_ack)
            svc <= svc | (4'h1 << irq_level);
        else if (irq_return)
            svc <= svc & ~(4'h1 << top);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    above_service_a: assert property (irq_request && svc != 4'h0 |-> irq_level > top)
        else $error("request at or below service");
    legal_vector_a: assert property (irq_request |-> irq_vector inside {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33, 8'h3b})
        else $error("bad vector");
    take_gap_a: assert property (irq_request && irq_ack |=> !irq_request)
        else $error("request after take");
    return_gap_a: assert property (irq_return |=> !irq_request)
        else $error("request after return");
    timer_clear_a: assert property (irq_request && irq_ack && irq_vector == 8'h0b |-> ##[1:2] request_flag_clear == 8'h02)
        else $error("timer flag not cleared");
    clear_pulse_a: assert property (request_flag_clear != 8'h00 |-> (request_flag_clear & 8'hf5) == 8'h00 ##1 request_flag_clear == 8'h00)
        else $error("bad flag clear");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : irq_prio_checker
////////////////////////////////////////////////////////////////////////////////
bind four_level_interrupt_priority irq_prio_checker u_irq_prio_checker (.*);

// file: dv/core_seq_model.sv
`timescale 1ns/1ns
module core_seq_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       irq_request,
    input  wire logic [7:0] irq_vector,
    input  wire logic [1:0] irq_level,
    input  wire logic [7:0] request_flag_clear,
    input  wire logic       accept_en,
    input  wire logic [3:0] ack_delay,
    input  wire logic       ret_cmd,
    input  wire logic [7:0] req_set,
    input  wire logic [7:0] req_drop,
    output logic            irq_ack,
    output logic            irq_return,
    output logic      [7:0] periph_request,
    output logic      [7:0] taken_vec,
    output logic      [1:0] taken_lvl,
    output logic      [7:0] taken_cnt
);
    logic [3:0] wait_cnt;
    // Ack after a settable delay; dropped on a take
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            taken_cnt <= 8'h00;
            taken_vec <= 8'h00;
            taken_lvl <= 2'h0;
        end
        else if (irq_ack && irq_request)
        begin
            irq_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            taken_cnt <= taken_cnt + 8'h01;
            taken_vec <= irq_vector;
            taken_lvl <= irq_level;
        end
        else
        begin
            wait_cnt <= (irq_request && accept_en) ? wait_cnt + 4'h1 : 4'h0;
            irq_ack  <= irq_request && accept_en && wait_cnt >= ack_delay;
        end
    end
    always_ff @(posedge aclk)
        irq_return <= aresetn && ret_cmd;
    // Flags stay until dropped or cleared by hardware
    always_ff @(posedge aclk)
        periph_request <= aresetn ? (periph_request | req_set) & ~req_drop & ~request_flag_clear : 8'h00;
endmodule : core_seq_model

// file: dv/four_level_interrupt_priority_tb_top.sv
`timescale 1ns/1ns
module four_level_interrupt_priority_tb_top
    import irq_prio_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic        ext0_pin_n, ext1_pin_n, irq_request, irq_ack, irq_return, irq, accept_en, ret_cmd;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, ack_delay;
    logic [1:0]  bresp, rresp, irq_level, taken_lvl, resp;
    logic [7:0]  periph_request, request_flag_clear, irq_vector, taken_vec, taken_cnt, req_set, req_drop;
    logic [7:0]  up, lo, c, d;
    logic [15:0] lfsr_q;
    logic [7:0]  vec_of [8];
    int          order [8];
    int          miscompares, samples_checked;

    four_level_interrupt_priority u_four_level_interrupt_priority (
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .*);
    core_seq_model u_core_seq_model (.*);
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic a_ok = 1'b0, w_ok = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(a_ok && w_ok))
        begin
            @(posedge aclk);
            a_ok = a_ok || awready;
            w_ok = w_ok || wready;
            awvalid <= !a_ok;
            wvalid  <= !w_ok;
        end
        while (bvalid !== 1'b1)
            @(posedge aclk);
        bready <= 1'b1;
        @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (arready !== 1'b1);
        arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
    // Ext sources go through their pins
    task automatic raise(input int s);
        if (s == 0)
            ext0_pin_n <= 1'b0;
        else if (s == 2)
            ext1_pin_n <= 1'b0;
        else
            req_set <= 8'h01 << s;
        @(posedge aclk);
        req_set <= 8'h00;
    endtask : raise
    // Waits out the pin synchroniser
    task automatic drop(input int s);
        if (s == 0)
            ext0_pin_n <= 1'b1;
        else if (s == 2)
            ext1_pin_n <= 1'b1;
        else
            req_drop <= 8'h01 << s;
        @(posedge aclk);
        req_drop <= 8'h00;
        repeat (5) @(posedge aclk);
    endtask : drop
    task automatic ret();
        ret_cmd <= 1'b1;
        @(posedge aclk);
        ret_cmd <= 1'b0;
        @(posedge aclk);
    endtask : ret
    task automatic expect_take(input int s, input logic [1:0] lv);
        int n;
        n = 0;
        c = taken_cnt;
        while (taken_cnt === c && n < 60)
        begin
            @(posedge aclk);
            n++;
        end
        check("taken", taken_cnt, c + 8'h01);
        check("vector", taken_vec, vec_of[s]);
        check("level", taken_lvl, lv);
    endtask : expect_take
    task automatic expect_hold();
        c = taken_cnt;
        repeat (15) @(posedge aclk);
        check("hold", taken_cnt, c);
    endtask : expect_hold
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, accept_en, ret_cmd} = 8'h00;
        {ext0_pin_n, ext1_pin_n} = 2'h3;
        {awaddr, araddr, wdata, req_set, req_drop} = '0;
        wstrb = 4'hf;
        ack_delay = 4'h0;
        lfsr_q = 16'h636d;
        vec_of = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33, 8'h3b};
        order = '{0, 5, 1, 2, 3, 4, 7, 6};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h2a0);
        check("enable_primary", d, RST_REG);
        rd(12'h2dc);
        check("priority_upper", d, RST_REG);
        lfsr_q = lfsr_next(lfsr_q);
        {lo, up} = lfsr_q;
        wr(12'h2dc, up);
        wr(12'h2e0, lo);
        rd(12'h2dc);
        check("priority_upper", d, up);
        rd(12'h004);
        check("unmapped_read", {resp, d}, {RESP_SLVERR, 8'h00});
        wr(12'h004, 8'h5a);
        check("unmapped_write", resp, RESP_SLVERR);
        $display("test registers done");
        wr(12'h2a0, 8'hff);
        wr(12'h3a0, 8'h01);
        accept_en <= 1'b1;
        for (int s = 0; s < 8; s++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            ack_delay <= {2'h0, lfsr_q[1:0]};
            raise(s);
            expect_take(s, {up[s], lo[s]});
            rd(12'h3c8);
            check("in_service", d & 8'h0f, 8'h01 << {up[s], lo[s]});
            drop(s);
            ret();
        end
        $display("test sources done");
        {up, lo} = 16'h0000;
        wr(12'h2dc, up);
        wr(12'h2e0, lo);
        wr(12'h3a4, 8'h03);
        accept_en <= 1'b0;
        {ext0_pin_n, ext1_pin_n} <= 2'h0;
        req_set <= 8'hfa;
        @(posedge aclk);
        req_set <= 8'h00;
        repeat (8) @(posedge aclk);
        accept_en <= 1'b1;
        // Equal-level flags must be vectored in poll order
        for (int k = 0; k < 8; k++)
        begin
            expect_take(order[k], 2'h0);
            drop(order[k]);
            ret();
        end
        $display("test polling done");
        {up, lo} = 16'h5210;
        wr(12'h2dc, up);
        wr(12'h2e0, lo);
        raise(1);
        expect_take(1, 2'h2);
        raise(6);
        expect_hold();
        raise(4);
        expect_take(4, 2'h3);
        drop(4);
        ret();
        expect_hold();
        ret();
        expect_take(6, 2'h2);
        drop(6);
        ret();
        rd(12'h3c8);
        check("in_service", d & 8'h0f, 8'h00);
        $display("test nesting done");
        wr(12'h2a0, 8'h7f);
        raise(5);
        expect_hold();
        accept_en <= 1'b0;
        wr(12'h2a0, 8'hff);
        accept_en <= 1'b1;
        expect_take(5, 2'h0);
        drop(5);
        ret();
        $display("test global enable done");
        rd(12'h3c0);
        check("event_status", d & 8'h07, 8'h07);
        wr(12'h3c4, 8'h01);
        check("irq", irq, 1'b1);
        wr(12'h3c0, 8'h0f);
        check("irq", irq, 1'b0);
        ret();
        rd(12'h3c0);
        check("idle_return", d, 8'h08);
        check("irq", irq, 1'b0);
        wr(12'h3c4, 8'h08);
        check("irq", irq, 1'b1);
        wr(12'h3c0, 8'h08);
        check("irq", irq, 1'b0);
        $display("test interrupts done");
        tally_and_finish();
    end
    // Cuts a hang well after the few hundred cycles needed
    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        tally_and_finish();
    end
endmodule : four_level_interrupt_priority_tb_top
